// ---- common/dac_cfg.svh ----
// register map, field positions, reset values and timing for the converter control block
// assumes a 10 MHz single clock and a byte-wide register port
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH

`define DAC_OFS_CTRL    8'h00
`define DAC_OFS_CODE    8'h01
`define DAC_BIT_ENABLE  0
`define DAC_BIT_PIN_OUTPUT_DRIVE_ON   6
`define DAC_BIT_STDBY   7
`define DAC_CTRL_WMASK  8'hc1
`define DAC_CTRL_RST    8'h00
`define DAC_CODE_RST    8'h00
`define DAC_BYTE_ZERO   8'h00
`define DAC_CLK_MHZ     10
`define DAC_WAKE_NS     1000
`define DAC_WAKE_CYCLES ((`DAC_WAKE_NS * `DAC_CLK_MHZ + 999) / 1000)

`endif

// ---- common/dac_pkg.sv ----
// shared types of the converter control block
// assumes dac_cfg.svh for all numeric constants
package dac_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [7:0] bus_addr_t;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } conv_state_e;
endpackage

// ---- common/dac_wake_if.sv ----
// carrier between the control top, its sleep gate and its wake timer
// assumes all three sit on ref_clk
`timescale 1ns/1ps
interface dac_wake_if;
  logic start;
  logic done;
  logic standby;
  logic powerdown;
  logic keep_run;
  logic clk_present;
  logic power_allowed;

  modport ctrl  (output start, standby, powerdown, keep_run, clk_present,
                 input  done, power_allowed);
  modport timer (input start, output done);
  modport gate  (input standby, powerdown, keep_run, clk_present, output power_allowed);
endinterface

// ---- design/dac_sleep_gate.sv ----
// decides whether the converter may stay powered in the present sleep mode
// assumes sleep-mode levels come from logic on ref_clk
`timescale 1ns/1ps
module dac_sleep_gate (
  dac_wake_if.gate w  // sleep levels in, power permission out
);
  always_comb begin
    w.power_allowed = !w.powerdown
                      && (!w.standby || (w.keep_run && w.clk_present));
  end
endmodule // dac_sleep_gate

// ---- design/dac_wake_timer.sv ----
// start-up delay counter used when the converter wakes from sleep
// assumes start is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
`include "dac_cfg.svh"
module dac_wake_timer #(
  parameter int unsigned WAKE_CYCLES = `DAC_WAKE_CYCLES  // start-up delay in cycles
) (
  input  wire logic ref_clk,  // system clock
  input  wire logic rst_n,    // synchronised reset, active low
  dac_wake_if.timer w         // start pulse in, done out
);
  localparam int unsigned CW = $clog2(WAKE_CYCLES + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (w.start) begin
      next_cnt = CW'(WAKE_CYCLES);
    end else if (cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // done ignores start: start only comes while sleeping, so no path loops back
  assign w.done = (cnt == CW'(1));
endmodule // dac_wake_timer

// ---- design/dac_control_logic.sv ----
// control side of an 8-bit voltage-output converter: registers, power and conversion start
// assumes sleep levels and clock-present come from logic on ref_clk; analog core lies outside
`timescale 1ns/1ps
`include "dac_cfg.svh"

// How it works
// - enable bit written one turns converter on; written zero turns it off
// - pin drive bit six powers the output buffer and routes output to pin
// - while running, each code write starts a new conversion at once
// - while disabled, code writes only store; writing enable one then converts
// - standby keeps converting only with keep-running bit set and clock present
// - stopped in standby powers core and buffer off; wake waits start-up delay
// - power-down sleep always turns core and buffer off
// - internal comparator and ADC see the output whenever converter runs
// - code register at offset one holds eight bits, resets to zero
// - processor halt for debug leaves converter state and output untouched
module dac_control_logic #(
  parameter int unsigned WAKE_CYCLES = `DAC_WAKE_CYCLES  // start-up delay in cycles
) (
  input  wire logic              ref_clk,         // 10 MHz clock
  input  wire logic              rstn,            // async reset, active low
  input  wire dac_pkg::bus_addr_t addr,           // register address
  input  wire dac_pkg::byte_t    wdata,           // write data
  input  wire logic              wr,              // write strobe
  input  wire logic              rd,              // read strobe
  output      dac_pkg::byte_t    rdata,           // read data, cycle after rd
  input  wire logic              sleep_standby,   // device in standby sleep
  input  wire logic              sleep_powerdown, // device in power-down sleep
  input  wire logic              per_clk_present, // peripheral clock kept in sleep
  output      logic              core_on,         // analog core powered
  output      logic              buffer_on,       // output buffer on, output on pin
  output      logic              internal_on,     // output offered to comparator and ADC
  output      logic              conv_start,      // one-cycle conversion start
  output      dac_pkg::byte_t    conv_code        // code being converted
);
  import dac_pkg::*;

  function automatic logic reg_hit(input bus_addr_t a, input bus_addr_t ofs);
    return a == ofs;
  endfunction

  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // register file
  byte_t ctrl;
  byte_t code;
  byte_t next_ctrl;
  byte_t next_code;
  byte_t next_rdata;
  logic  ctrl_write;
  logic  code_write;

  always_comb begin
    ctrl_write = wr && reg_hit(addr, `DAC_OFS_CTRL);
    code_write = wr && reg_hit(addr, `DAC_OFS_CODE);
    next_ctrl  = ctrl;
    next_code  = code;
    next_rdata = `DAC_BYTE_ZERO;
    if (ctrl_write) begin
      next_ctrl = wdata & `DAC_CTRL_WMASK;
    end
    if (code_write) begin
      next_code = wdata;
    end
    if (rd && reg_hit(addr, `DAC_OFS_CTRL)) begin
      next_rdata = ctrl & `DAC_CTRL_WMASK;
    end else if (rd && reg_hit(addr, `DAC_OFS_CODE)) begin
      next_rdata = code;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl  <= `DAC_CTRL_RST;
      code  <= `DAC_CODE_RST;
      rdata <= `DAC_BYTE_ZERO;
    end else begin
      ctrl  <= next_ctrl;
      code  <= next_code;
      rdata <= next_rdata;
    end
  end

  // sleep gate and wake timer
  dac_wake_if w ();
  logic wake_start;

  assign w.start       = wake_start;
  assign w.standby     = sleep_standby;
  assign w.powerdown   = sleep_powerdown;
  assign w.keep_run    = ctrl[`DAC_BIT_STDBY];
  assign w.clk_present = per_clk_present;

  dac_sleep_gate u_gate (
    .w (w.gate)
  );

  dac_wake_timer #(
    .WAKE_CYCLES (WAKE_CYCLES)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .w       (w.timer)
  );

  // conversion and power state; no debug-halt input, so a halt changes nothing
  conv_state_e state;
  conv_state_e next_state;
  logic        next_conv_start;
  byte_t       next_conv_code;
  logic        en_now;
  logic        run_next;
  logic        power_next;

  always_comb begin
    en_now          = next_ctrl[`DAC_BIT_ENABLE];
    next_state      = state;
    next_conv_start = 1'b0;
    next_conv_code  = conv_code;
    wake_start      = 1'b0;
    unique case (state)
      ST_OFF: begin
        if (en_now && w.power_allowed) begin
          next_state      = ST_RUN;
          next_conv_start = 1'b1;
          next_conv_code  = next_code;
        end else if (en_now) begin
          next_state = ST_SLEEP;
        end
      end
      ST_RUN: begin
        if (!en_now) begin
          next_state = ST_OFF;
        end else if (!w.power_allowed) begin
          next_state = ST_SLEEP;
        end else if (code_write) begin
          next_conv_start = 1'b1;
          next_conv_code  = wdata;
        end
      end
      ST_SLEEP: begin
        if (!en_now) begin
          next_state = ST_OFF;
        end else if (w.power_allowed) begin
          next_state = ST_WAKE;
          wake_start = 1'b1;
        end
      end
      ST_WAKE: begin
        if (!en_now) begin
          next_state = ST_OFF;
        end else if (!w.power_allowed) begin
          next_state = ST_SLEEP;
        end else if (w.done) begin
          next_state      = ST_RUN;
          next_conv_start = 1'b1;
          next_conv_code  = next_code;
        end
      end
    endcase
    run_next   = next_state == ST_RUN;
    power_next = run_next || next_state == ST_WAKE;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_OFF;
      conv_start  <= 1'b0;
      conv_code   <= `DAC_CODE_RST;
      core_on     <= 1'b0;
      buffer_on   <= 1'b0;
      internal_on <= 1'b0;
    end else begin
      state       <= next_state;
      conv_start  <= next_conv_start;
      conv_code   <= next_conv_code;
      core_on     <= power_next;
      buffer_on   <= power_next && next_ctrl[`DAC_BIT_PIN_OUTPUT_DRIVE_ON];
      internal_on <= run_next;
    end
  end

  // cycles spent waking, watched by the start-up check
  logic [15:0] wake_age;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_age <= 16'h0000;
    end else if (state != ST_WAKE) begin
      wake_age <= 16'h0000;
    end else begin
      wake_age <= wake_age + 16'h0001;
    end
  end

  a_enable_powers_core: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_OFF && ctrl_write && wdata[`DAC_BIT_ENABLE] && w.power_allowed)
      |=> core_on && internal_on)
    else $error("enable write did not power the converter");

  a_disable_drops_core: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ctrl_write && !wdata[`DAC_BIT_ENABLE])
      |=> !core_on && !buffer_on && !internal_on && state == ST_OFF)
    else $error("disable write left the converter on");

  a_buffer_follows_bit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_RUN && w.power_allowed && ctrl_write
      && wdata[`DAC_BIT_ENABLE] && wdata[`DAC_BIT_PIN_OUTPUT_DRIVE_ON])
      |=> buffer_on ##1 (buffer_on || $past(wr) || !$past(w.power_allowed)))
    else $error("pin drive bit did not turn on the buffer");

  a_write_converts: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_RUN && w.power_allowed && code_write)
      |=> conv_start && conv_code == $past(wdata) && code == $past(wdata))
    else $error("code write while running did not start a conversion");

  a_idle_write_stores: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_OFF && code_write && !sleep_standby && !sleep_powerdown)
      |=> !conv_start && code == $past(wdata) && !core_on)
    else $error("code write while disabled converted or was lost");

  a_enable_converts: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_OFF && ctrl_write && wdata[`DAC_BIT_ENABLE] && w.power_allowed)
      |=> conv_start && conv_code == code)
    else $error("enable write did not convert the stored code");

  a_standby_stops: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_RUN && sleep_standby && !ctrl[`DAC_BIT_STDBY] && !wr)
      |=> !core_on && !buffer_on && state == ST_SLEEP)
    else $error("converter kept running into standby");

  a_standby_keeps: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_RUN && sleep_standby && !sleep_powerdown && per_clk_present
      && ctrl[`DAC_BIT_STDBY] && !wr)
      |=> core_on && state == ST_RUN)
    else $error("keep-running setting did not hold converter in standby");

  a_wake_delay: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_WAKE && next_state == ST_RUN)
      |-> wake_age == 16'(WAKE_CYCLES - 1))
    else $error("wake start-up delay has the wrong length");

  a_powerdown_off: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sleep_powerdown |=> !core_on && !buffer_on && !internal_on)
    else $error("converter stayed on in power-down");

  a_internal_route: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(internal_on)
      |-> ctrl[`DAC_BIT_ENABLE] && state == ST_RUN && !$past(sleep_powerdown))
    else $error("internal route opened without a running converter");

  a_unused_bits_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (rd && reg_hit(addr, `DAC_OFS_CTRL)) |=> rdata[5:1] == 5'h0)
    else $error("unused control bits read nonzero");

  a_buffer_needs_bit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    buffer_on
      |-> core_on && ctrl[`DAC_BIT_PIN_OUTPUT_DRIVE_ON])
    else $error("output buffer on without its pin drive bit");

  a_internal_needs_enable: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    internal_on
      |-> core_on && ctrl[`DAC_BIT_ENABLE])
    else $error("internal route open while converter disabled");

  a_sleep_no_start: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_SLEEP)
      |=> !conv_start && !internal_on)
    else $error("conversion started straight out of sleep");

  a_start_single: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (conv_start && !code_write)
      |=> !conv_start)
    else $error("conversion start without a new cause");
endmodule // dac_control_logic

// ---- test/tb.sv ----
// self-checking bench for the converter control block: registers, conversion start, sleep
// assumes dac_pkg is compiled first and the design reaches dac_cfg.svh by include path
`timescale 1ns/1ps
module tb;
  import dac_pkg::*;
  localparam int unsigned WAKE      = 2;
  localparam bus_addr_t   ADDR_CTRL = 8'h00;
  localparam bus_addr_t   ADDR_CODE = 8'h01;
  localparam bus_addr_t   ADDR_NONE = 8'h05;

  logic        ref_clk;
  logic        rstn;
  bus_addr_t   addr;
  byte_t       wdata;
  logic        wr;
  logic        rd;
  byte_t       rdata;
  logic        sleep_standby;
  logic        sleep_powerdown;
  logic        per_clk_present;
  logic        core_on;
  logic        buffer_on;
  logic        internal_on;
  logic        conv_start;
  byte_t       conv_code;
  int          err_count;
  int          total_checks;
  int          seed;
  byte_t       code;

  dac_control_logic #(.WAKE_CYCLES(WAKE)) DUT (
    .ref_clk         (ref_clk),
    .rstn            (rstn),
    .addr            (addr),
    .wdata           (wdata),
    .wr              (wr),
    .rd              (rd),
    .rdata           (rdata),
    .sleep_standby   (sleep_standby),
    .sleep_powerdown (sleep_powerdown),
    .per_clk_present (per_clk_present),
    .core_on         (core_on),
    .buffer_on       (buffer_on),
    .internal_on     (internal_on),
    .conv_start      (conv_start),
    .conv_code       (conv_code)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // only bits 7, 6 and 0 of the control byte are kept
  function automatic byte_t ctrl_view(byte_t w);
    return {w[7], w[6], 5'h00, w[0]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one cycle; drives land just after the edge, checks see settled outputs
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(byte_t got, byte_t exp, string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pwr(logic [2:0] exp);
    chk({5'h00, core_on, buffer_on, internal_on}, {5'h00, exp}, "power outputs");
  endtask

  task automatic chk_start(logic exp, byte_t c);
    chk({7'h00, conv_start}, {7'h00, exp}, "conversion start");
    if (exp)
      chk(conv_code, c, "conversion code");
  endtask

  task automatic bus_wr(bus_addr_t a, byte_t d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    rd    <= 1'b0;
    tick();
  endtask

  task automatic bus_rd(bus_addr_t a, byte_t exp);
    addr <= a;
    rd   <= 1'b1;
    wr   <= 1'b0;
    tick();
    chk(rdata, exp, "read data");
  endtask

  task automatic idle(int unsigned n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) tick();
  endtask

  task automatic wait_start(int unsigned bound, byte_t c);
    int unsigned n;
    n = 0;
    while (conv_start !== 1'b1 && n < bound) begin
      tick();
      n++;
    end
    if (conv_start !== 1'b1) begin
      err_count++;
      $display("ERROR %0t no conversion start after wake", $time);
    end else begin
      chk_start(1'b1, c);
    end
  endtask

  initial begin
    rstn            = 1'b0;
    addr            = 8'h00;
    wdata           = 8'h00;
    wr              = 1'b0;
    rd              = 1'b0;
    sleep_standby   = 1'b0;
    sleep_powerdown = 1'b0;
    per_clk_present = 1'b0;
    err_count       = 0;
    total_checks    = 0;
    seed            = 50153;
    code            = 8'h00;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) tick();
    chk_pwr(3'b000);
    bus_rd(ADDR_CTRL, 8'h00);
    bus_rd(ADDR_CODE, 8'h00);
    bus_wr(ADDR_CTRL, 8'h3e);
    bus_wr(ADDR_NONE, 8'hff);
    bus_rd(ADDR_CTRL, 8'h00);
    bus_rd(ADDR_NONE, 8'h00);
    bus_rd(ADDR_CODE, 8'h00);
    chk_pwr(3'b000);
    // disabled: code writes are stored, never converted
    for (int i = 0; i < 5; i++) begin
      code = (i == 0) ? 8'hff : byte_t'($random(seed));
      bus_wr(ADDR_CODE, code);
      chk_start(1'b0, code);
      bus_rd(ADDR_CODE, code);
    end
    bus_wr(ADDR_CTRL, 8'h41);
    chk_pwr(3'b111);
    chk_start(1'b1, code);
    bus_rd(ADDR_CTRL, ctrl_view(8'h41));
    chk_start(1'b0, code);
    // enabled: back-to-back code writes each convert
    for (int i = 0; i < 6; i++) begin
      code = (i == 0) ? 8'h00 : byte_t'($random(seed));
      bus_wr(ADDR_CODE, code);
      chk_start(1'b1, code);
    end
    bus_rd(ADDR_CODE, code);
    bus_wr(ADDR_CTRL, 8'h01);
    chk_pwr(3'b101);
    bus_wr(ADDR_CTRL, 8'h41);
    idle(1);
    // standby without keep-running: off, then wake with delay
    sleep_standby <= 1'b1;
    tick();
    chk_pwr(3'b000);
    code = byte_t'($random(seed));
    bus_wr(ADDR_CODE, code);
    chk_start(1'b0, code);
    idle(1);
    chk_pwr(3'b000);
    sleep_standby <= 1'b0;
    tick();
    chk_pwr(3'b110);
    wait_start(WAKE + 2, code);
    chk_pwr(3'b111);
    // keep-running with clock present stays on
    bus_wr(ADDR_CTRL, 8'hc1);
    idle(1);
    per_clk_present <= 1'b1;
    sleep_standby   <= 1'b1;
    repeat (4) begin
      tick();
      chk_pwr(3'b111);
    end
    sleep_powerdown <= 1'b1;
    tick();
    chk_pwr(3'b000);
    sleep_powerdown <= 1'b0;
    sleep_standby   <= 1'b0;
    wait_start(WAKE + 3, code);
    per_clk_present <= 1'b0;
    sleep_standby   <= 1'b1;
    tick();
    chk_pwr(3'b000);
    sleep_standby <= 1'b0;
    wait_start(WAKE + 3, code);
    bus_wr(ADDR_CTRL, 8'h40);
    chk_pwr(3'b000);
    bus_wr(ADDR_CODE, 8'h5a);
    chk_start(1'b0, 8'h5a);
    bus_rd(ADDR_CTRL, ctrl_view(8'h40));
    // enable while standby blocks power: sleep first, then wake and convert
    idle(1);
    sleep_standby <= 1'b1;
    bus_wr(ADDR_CTRL, 8'h41);
    chk_pwr(3'b000);
    idle(1);
    chk_pwr(3'b000);
    sleep_standby <= 1'b0;
    tick();
    chk_pwr(3'b110);
    wait_start(WAKE + 2, 8'h5a);
    chk_pwr(3'b111);
    // mid-run reset returns registers and outputs to zero
    rstn <= 1'b0;
    tick();
    chk_pwr(3'b000);
    rstn <= 1'b1;
    repeat (3) tick();
    chk_pwr(3'b000);
    bus_rd(ADDR_CODE, 8'h00);
    bus_rd(ADDR_CTRL, 8'h00);
    idle(2);
    print_verdict();
  end
endmodule // tb
